// ---- logic/wave_timing_pkg.sv ----
// shared constants and carrier types for the waveform output timing block
package wave_timing_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_START_CFG = 8'h04;
  localparam logic [7:0] OFS_PAUSE_CFG = 8'h08;
  localparam logic [7:0] OFS_DIVISOR = 8'h0c;
  localparam logic [7:0] OFS_DELAY = 8'h10;
  localparam logic [7:0] OFS_TIME_LO = 8'h14;
  localparam logic [7:0] OFS_TIME_HI = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_NOW_LO = 8'h20;
  localparam logic [7:0] OFS_NOW_HI = 8'h24;

  // control register fields
  localparam int CTRL_SW_START = 0;
  localparam int CTRL_SW_PULSE = 1;
  localparam int CTRL_STOP = 2;
  localparam int CTRL_EXT_TB = 3;
  localparam int CTRL_TB_SEL_LO = 4;
  localparam int CTRL_FILT_EN = 6;
  localparam int CTRL_SYNC_PULSE = 7;

  // timebase selection codes
  localparam logic [1:0] TB_AUTO = 2'h0;
  localparam logic [1:0] TB_10M = 2'h1;
  localparam logic [1:0] TB_12M8 = 2'h2;
  localparam logic [1:0] TB_13M1 = 2'h3;

  // start trigger sources
  localparam logic [2:0] SRC_NONE = 3'h0;
  localparam logic [2:0] SRC_HOST_PULSE = 3'h1;
  localparam logic [2:0] SRC_TERMINAL = 3'h2;
  localparam logic [2:0] SRC_IN_REF = 3'h3;
  localparam logic [2:0] SRC_IN_START = 3'h4;
  localparam logic [2:0] SRC_INTERNAL = 3'h5;
  localparam logic [2:0] SRC_ANALOG = 3'h6;
  localparam logic [2:0] SRC_TIME = 3'h7;

  // pause trigger sources
  localparam logic [1:0] PSRC_NONE = 2'h0;
  localparam logic [1:0] PSRC_TERMINAL = 2'h1;
  localparam logic [1:0] PSRC_INTERNAL = 2'h2;
  localparam logic [1:0] PSRC_ANALOG = 2'h3;

  // reset value and default filter length
  localparam logic [31:0] DIVISOR_RST = 32'h0000_0001;
  localparam int FILT_LEN = 4;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_DELAY = 2'b11,
    ST_RUN = 2'b10
  } run_state_t;

  typedef struct packed {
    logic [2:0] src;
    logic falling;
    logic [3:0] term;
  } start_cfg_t;

  typedef struct packed {
    logic [1:0] src;
    logic active_low;
    logic [3:0] term;
  } pause_cfg_t;

endpackage

// ---- logic/wave_timing.sv ----
// waveform output timebase, start trigger and pause trigger control
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/100ps

// Notes on behaviour
// - three timebases; auto picks fastest one the task's modules offer
// - update clock is internal timebase divided by an integer divisor; external clock used undivided
// - timebase internal or external; never driven onto an output
// - generation starts on start trigger, or software start without trigger
// - programmable start delay when update clock is internal, not applied on software start without trigger
// - digital start source selectable, rising or falling edge
// - analog comparison start on first configured edge
// - time source raises start trigger at the programmed absolute time
// - start trigger routed out as active-high pulse
// - pause suppresses new samples, sample in progress completes
// - onboard clock: resume at once after pause deasserts
// - other clock: resume after deassert plus a further clock edge
// - digital pause from terminal or internal, configured level
// - analog comparison pause at configured level
// - same sync pulse aligns tasks, else implicit software pulse
// - update clock marks simultaneous update, active high out
// - clock, start and pause inputs optionally filtered
module wave_timing import wave_timing_pkg::*; #(
  parameter int NTERM = 16,
  parameter int FLEN = FILT_LEN
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // timebase sources
  input wire logic [2:0] timebase_avail,
  input wire logic ext_update_clock,
  // trigger sources
  input wire logic [NTERM-1:0] programmable_trigger_terminal,
  input wire logic in_ref_trigger,
  input wire logic in_start_trigger,
  input wire logic internal_trigger,
  input wire logic analog_compare_event,
  // outputs to the output modules
  output logic [1:0] update_timebase,
  output logic output_update_clock,
  output logic output_start_trigger,
  output logic output_pause_trigger,
  output logic sync_pulse,
  output logic running
);

  initial begin
    if (NTERM < 1 || NTERM > 16) $error("NTERM must be 1..16");
    if (FLEN < 2 || FLEN > 8) $error("FLEN must be 2..8");
  end

  typedef struct packed {
    logic [31:0] rdata;
    logic ext_tb;
    logic [1:0] tb_sel;
    logic filt_en;
    start_cfg_t scfg;
    pause_cfg_t pcfg;
    logic [31:0] divisor;
    logic [31:0] delay;
    logic [63:0] trig_time;
    logic [63:0] now;
    logic [31:0] div_cnt;
    logic [31:0] dly_cnt;
    run_state_t st;
    logic [1:0] tb;
    logic [NTERM-1:0] t1, t2, t3;
    logic [3:0] a1, a2, a3;
    // last agreed level of each synchronised input, held while stages disagree
    logic [NTERM-1:0] th;
    logic [3:0] ah;
    logic [FLEN-1:0] fs, fp, fc;
    logic start_q, clk_q;
    logic pause_lvl;
    logic resume_wait;
    logic upd;
    logic strig;
    logic sync;
    logic host_pulse;
  } state_t;

  state_t s_r, s_nxt;

  logic wr, rd;
  logic start_raw, pause_raw, clk_raw;
  logic start_f, pause_f, clk_f;
  logic start_edge, clk_edge, tick, pause_now;
  logic [3:0] asy_now;
  logic [NTERM-1:0] tnow;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  // a change counts only once stages two and three agree, in either direction
  assign asy_now = (~(s_r.a2 ^ s_r.a3) & s_r.a3) | ((s_r.a2 ^ s_r.a3) & s_r.ah);
  assign tnow = (~(s_r.t2 ^ s_r.t3) & s_r.t3) | ((s_r.t2 ^ s_r.t3) & s_r.th);

  // optional majority-free filter: output is the oldest of FLEN samples, so any level passes FLEN-1 cycles late
  function automatic logic filt(input logic [FLEN-1:0] h, input logic en);
    if (!en) begin
      return h[0];
    end
    return (&h) ? 1'b1 : ((|h) ? h[FLEN-1] : 1'b0);
  endfunction

  always_comb begin
    s_nxt = s_r;
    // three-stage sync, a change counts once stages two and three agree
    s_nxt.t1 = programmable_trigger_terminal;
    s_nxt.t2 = s_r.t1;
    s_nxt.t3 = s_r.t2;
    s_nxt.a1 = {ext_update_clock, analog_compare_event, in_ref_trigger, in_start_trigger};
    s_nxt.a2 = s_r.a1;
    s_nxt.a3 = s_r.a2;
    s_nxt.ah = asy_now;
    s_nxt.th = tnow;
    s_nxt.upd = 1'b0;
    s_nxt.strig = 1'b0;
    s_nxt.sync = 1'b0;
    s_nxt.host_pulse = 1'b0;
    s_nxt.now = s_r.now + 64'h0000_0000_0000_0001;

    // source selection
    start_raw = 1'b0;
    case (s_r.scfg.src)
      SRC_HOST_PULSE: start_raw = s_r.host_pulse;
      SRC_TERMINAL: start_raw = tnow[s_r.scfg.term];
      SRC_IN_REF: start_raw = asy_now[1];
      SRC_IN_START: start_raw = asy_now[0];
      SRC_INTERNAL: start_raw = internal_trigger;
      SRC_ANALOG: start_raw = asy_now[2];
      default: start_raw = 1'b0;
    endcase
    pause_raw = 1'b0;
    case (s_r.pcfg.src)
      PSRC_TERMINAL: pause_raw = tnow[s_r.pcfg.term];
      PSRC_INTERNAL: pause_raw = internal_trigger;
      PSRC_ANALOG: pause_raw = asy_now[2];
      default: pause_raw = 1'b0;
    endcase
    clk_raw = asy_now[3];

    // filter histories
    s_nxt.fs = {s_r.fs[FLEN-2:0], start_raw};
    s_nxt.fp = {s_r.fp[FLEN-2:0], pause_raw};
    s_nxt.fc = {s_r.fc[FLEN-2:0], clk_raw};
    start_f = filt(s_r.fs, s_r.filt_en);
    pause_f = filt(s_r.fp, s_r.filt_en);
    clk_f = filt(s_r.fc, s_r.filt_en);
    s_nxt.start_q = start_f;
    s_nxt.clk_q = clk_f;
    start_edge = s_r.scfg.falling ? (s_r.start_q && !start_f) : (!s_r.start_q && start_f);
    clk_edge = !s_r.clk_q && clk_f;

    // pause level, polarity selectable
    pause_now = (s_r.pcfg.src != PSRC_NONE) && (pause_f ^ s_r.pcfg.active_low);
    s_nxt.pause_lvl = pause_now;

    // timebase choice: auto takes the fastest available
    if (s_r.tb_sel != TB_AUTO) begin
      s_nxt.tb = s_r.tb_sel;
    end else if (timebase_avail[2]) begin
      s_nxt.tb = TB_13M1;
    end else if (timebase_avail[1]) begin
      s_nxt.tb = TB_12M8;
    end else begin
      s_nxt.tb = TB_10M;
    end

    // update tick: integer division of internal timebase; each rising external clock edge ticks undivided
    tick = 1'b0;
    if (s_r.st == ST_RUN) begin
      if (s_r.ext_tb) begin
        tick = clk_edge;
      end else if (s_r.div_cnt >= s_r.divisor - 32'h0000_0001) begin
        tick = 1'b1;
        s_nxt.div_cnt = 32'h0000_0000;
      end else begin
        s_nxt.div_cnt = s_r.div_cnt + 32'h0000_0001;
      end
    end

    // pause: samples suppressed, running divider carries on
    if (pause_now) begin
      s_nxt.resume_wait = s_r.ext_tb;
    end else if (s_r.resume_wait && clk_edge) begin
      s_nxt.resume_wait = 1'b0;
    end
    if (tick && !pause_now && !s_r.resume_wait) begin
      s_nxt.upd = 1'b1;
    end

    case (s_r.st)
      ST_IDLE: begin
        s_nxt.div_cnt = 32'h0000_0000;
      end
      ST_ARMED: begin
        if ((s_r.scfg.src == SRC_TIME && s_r.now == s_r.trig_time) ||
            (s_r.scfg.src != SRC_TIME && s_r.scfg.src != SRC_NONE && start_edge)) begin
          s_nxt.strig = 1'b1;
          s_nxt.sync = 1'b1;
          s_nxt.dly_cnt = s_r.delay;
          s_nxt.st = (s_r.ext_tb || s_r.delay == 32'h0000_0000) ? ST_RUN : ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (s_r.dly_cnt <= 32'h0000_0001) begin
          s_nxt.st = ST_RUN;
        end else begin
          s_nxt.dly_cnt = s_r.dly_cnt - 32'h0000_0001;
        end
      end
      ST_RUN: ;
      default: s_nxt.st = ST_IDLE;
    endcase

    // register access, one wait-free cycle; read data latched in setup
    if (rd) begin
      case (paddr)
        OFS_CTRL: s_nxt.rdata = {24'h0, 1'b0, s_r.filt_en, s_r.tb_sel, s_r.ext_tb, 3'h0};
        OFS_START_CFG: s_nxt.rdata = {24'h0, s_r.scfg};
        OFS_PAUSE_CFG: s_nxt.rdata = {25'h0, s_r.pcfg};
        OFS_DIVISOR: s_nxt.rdata = s_r.divisor;
        OFS_DELAY: s_nxt.rdata = s_r.delay;
        OFS_TIME_LO: s_nxt.rdata = s_r.trig_time[31:0];
        OFS_TIME_HI: s_nxt.rdata = s_r.trig_time[63:32];
        OFS_STATUS: s_nxt.rdata = {26'h0, s_r.tb, s_r.resume_wait, pause_now, s_r.st};
        OFS_NOW_LO: s_nxt.rdata = s_r.now[31:0];
        OFS_NOW_HI: s_nxt.rdata = s_r.now[63:32];
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      case (paddr)
        OFS_CTRL: begin
          s_nxt.ext_tb = pwdata[CTRL_EXT_TB];
          s_nxt.tb_sel = pwdata[CTRL_TB_SEL_LO +: 2];
          s_nxt.filt_en = pwdata[CTRL_FILT_EN];
          s_nxt.host_pulse = pwdata[CTRL_SW_PULSE];
          // explicit sync pulse shared by tasks, implicit one at start
          s_nxt.sync = s_nxt.sync | pwdata[CTRL_SYNC_PULSE];
          if (pwdata[CTRL_STOP]) begin
            s_nxt.st = ST_IDLE;
          end else if (pwdata[CTRL_SW_START] && s_r.st == ST_IDLE) begin
            if (s_r.scfg.src == SRC_NONE) begin
              s_nxt.st = ST_RUN;
              s_nxt.strig = 1'b1;
              s_nxt.sync = 1'b1;
            end else begin
              s_nxt.st = ST_ARMED;
            end
          end
        end
        OFS_START_CFG: s_nxt.scfg = start_cfg_t'(pwdata[7:0]);
        OFS_PAUSE_CFG: s_nxt.pcfg = pause_cfg_t'(pwdata[6:0]);
        OFS_DIVISOR: s_nxt.divisor = (pwdata == 32'h0) ? DIVISOR_RST : pwdata;
        OFS_DELAY: s_nxt.delay = pwdata;
        OFS_TIME_LO: s_nxt.trig_time[31:0] = pwdata;
        OFS_TIME_HI: s_nxt.trig_time[63:32] = pwdata;
        default: ;
      endcase
    end
    // a stop in the same cycle as a tick must not leave a stray update behind
    if (s_nxt.st != ST_RUN) begin
      s_nxt.upd = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.divisor <= DIVISOR_RST;
      s_r.st <= ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  logic unmapped;
  assign unmapped = paddr > OFS_NOW_HI || paddr[1:0] != 2'b00;
  assign prdata = s_r.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && unmapped;
  // only the selection code leaves the block, never the timebase itself
  assign update_timebase = s_r.tb;
  assign output_update_clock = s_r.upd;
  assign output_start_trigger = s_r.strig;
  assign output_pause_trigger = s_r.pause_lvl;
  assign sync_pulse = s_r.sync;
  assign running = (s_r.st == ST_RUN);

endmodule

// ---- verification/wave_timing_properties.sv ----
// port-level assertions for the waveform timing block
`timescale 1ns/100ps
module wave_timing_checker import wave_timing_pkg::*; (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // timing
  input wire logic [1:0] update_timebase,
  input wire logic output_update_clock,
  input wire logic output_start_trigger,
  input wire logic output_pause_trigger,
  input wire logic sync_pulse,
  input wire logic running
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_high_a: assert property (psel && penable |-> pready) else $error("pready low");
  bad_addr_a: assert property (psel && penable && paddr > 8'h24 |-> pslverr)
    else $error("unmapped address not refused");
  start_pulse_a: assert property (output_start_trigger |=> !output_start_trigger)
    else $error("start trigger wider than one cycle");
  sync_pulse_a: assert property (sync_pulse |=> !sync_pulse)
    else $error("sync pulse wider than one cycle");
  idle_quiet_a: assert property (!running |-> !output_update_clock)
    else $error("update while not running");
  pause_mask_a: assert property (output_pause_trigger |-> !output_update_clock)
    else $error("update while paused");
  tb_code_a: assert property ($past(presetn) |-> update_timebase != 2'h0)
    else $error("no timebase selected");
  stop_halts_a: assert property (psel && penable && pwrite && paddr == OFS_CTRL &&
    pwdata == 32'h0000_0004 |-> ##[1:3] !running) else $error("stop ignored");
endmodule

bind wave_timing wave_timing_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .update_timebase(update_timebase), .running(running),
  .output_update_clock(output_update_clock), .output_start_trigger(output_start_trigger),
  .output_pause_trigger(output_pause_trigger), .sync_pulse(sync_pulse));

// ---- verification/out_module_model.sv ----
// output module and trigger terminal model: counts pulses, makes terminal edges
`timescale 1ns/100ps
module out_module_model #(
  parameter int TERM = 3
) (
  // clock and bench control
  input wire logic pclk,
  input wire logic clr,
  input wire logic fire,
  // from the block
  input wire logic output_update_clock,
  input wire logic output_start_trigger,
  // to the block and bench
  output logic [15:0] terminal,
  output logic [15:0] upd_cnt,
  output logic [15:0] start_cnt
);
  // terminals carry a plain level, one of them driven
  assign terminal = 16'(fire) << TERM;
  always_ff @(posedge pclk) begin
    upd_cnt <= clr ? 16'h0000 : upd_cnt + 16'(output_update_clock);
    start_cnt <= clr ? 16'h0000 : start_cnt + 16'(output_start_trigger);
  end
endmodule

// ---- verification/tb_wave_timing.sv ----
// self-checking bench for the waveform timing block
`timescale 1ns/100ps
module tb_wave_timing;
  import wave_timing_pkg::*;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, upd, st, pau, sync, running;
  logic itrig = 0;
  logic eclk = 0;
  logic clr = 0;
  logic fire = 0;
  logic [2:0] avail = 3'b011;
  logic [15:0] term, ucnt, scnt;
  logic [1:0] tb, h;
  // analog source: the bench stands in for the comparison set up by an input task
  logic [31:0] pc [5] = '{32'h40, 32'h50, 32'h50, 32'h60, 32'h00};
  logic lv [5] = '{1, 1, 0, 1, 0};
  logic [31:0] ex [5] = '{0, 10, 0, 0, 10};
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;

  initial forever #4 pclk = ~pclk;

  wave_timing u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timebase_avail(avail), .ext_update_clock(eclk),
    .programmable_trigger_terminal(term), .in_ref_trigger(1'b0), .in_start_trigger(1'b0),
    .internal_trigger(itrig), .analog_compare_event(itrig), .update_timebase(tb),
    .output_update_clock(upd), .output_start_trigger(st), .output_pause_trigger(pau),
    .sync_pulse(sync), .running(running));
  out_module_model u_mod (.pclk(pclk), .clr(clr), .fire(fire), .output_update_clock(upd),
    .output_start_trigger(st), .terminal(term), .upd_cnt(ucnt), .start_cnt(scnt));

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
      err_count++;
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // count update pulses over n cycles
  task automatic win(input int n);
    @(posedge pclk);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // clear the counters, then give n external clock periods of 8 cycles
  task automatic ext(input int n);
    @(posedge pclk);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    repeat (n) begin
      eclk <= 1'b1;
      repeat (4) @(posedge pclk);
      eclk <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    repeat (8) @(posedge pclk);
    #1;
  endtask

  // look for start and sync pulses at falling edges, where they are settled
  task automatic hit();
    h = 2'b00;
    repeat (20) begin
      @(negedge pclk);
      h = h | {sync === 1'b1, st === 1'b1};
    end
  endtask

  task automatic give_verdict();
    if (err_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFS_DIVISOR, 0);
    chk("divisor reset", rd, DIVISOR_RST);
    chk("auto timebase", 32'(tb), 32'(TB_12M8));
    apb(0, 8'h28, 0);
    chk("unmapped err", 32'(err), 32'h1);
    chk("unmapped data", rd, 32'h0);
    apb(1, OFS_DIVISOR, 32'h0000_0004);
    apb(1, OFS_CTRL, 32'h0000_0001);
    hit();
    chk("sw start pulses", 32'(h), 32'h3);
    win(40);
    chk("update rate", 32'(ucnt), 32'ha);
    for (int i = 0; i < 5; i++) begin
      apb(1, OFS_PAUSE_CFG, pc[i]);
      itrig <= lv[i];
      repeat (8) @(posedge pclk);
      win(40);
      chk("pause updates", 32'(ucnt), ex[i]);
      chk("pause out", 32'(pau), 32'(ex[i] == 0));
    end
    apb(1, OFS_CTRL, 32'h0000_0004);
    // terminal start on rising then falling edge, then host pulse
    for (int f = 0; f < 3; f++) begin
      apb(1, OFS_START_CFG, f < 2 ? 32'h43 | 32'(f << 4) : 32'h20);
      fire <= (f == 1);
      repeat (8) @(posedge pclk);
      apb(1, OFS_CTRL, 32'h0000_0001);
      repeat (10) @(posedge pclk);
      chk("armed idle", 32'(running), 32'h0);
      if (f < 2) begin
        fire <= (f == 0);
      end else begin
        apb(1, OFS_CTRL, 32'h0000_0002);
      end
      hit();
      chk("trigger start", 32'(h[0]), 32'h1);
      chk("running", 32'(running), 32'h1);
      apb(1, OFS_CTRL, 32'h0000_0004);
    end
    // absolute time start with a start delay on the internal clock
    apb(1, OFS_START_CFG, 32'h0000_00e0);
    apb(1, OFS_DELAY, 32'h0000_0014);
    apb(0, OFS_NOW_LO, 0);
    apb(1, OFS_TIME_LO, rd + 32'h0000_0064);
    apb(1, OFS_CTRL, 32'h0000_0001);
    repeat (40) @(posedge pclk);
    chk("time armed", 32'(running), 32'h0);
    repeat (45) @(posedge pclk);
    hit();
    chk("time start", 32'(h[0]), 32'h1);
    chk("delay wait", 32'(running), 32'h0);
    repeat (20) @(posedge pclk);
    chk("delay done", 32'(running), 32'h1);
    apb(1, OFS_CTRL, 32'h0000_0004);
    // external clock: one update per rising edge; after pause the first edge is used up
    apb(1, OFS_START_CFG, 32'h0000_0000);
    apb(1, OFS_PAUSE_CFG, 32'h0000_0040);
    itrig <= 1'b0;
    apb(1, OFS_CTRL, 32'h0000_0009);
    ext(10);
    chk("ext updates", 32'(ucnt), 32'h0000_000a);
    itrig <= 1'b1;
    repeat (4) @(posedge pclk);
    itrig <= 1'b0;
    ext(3);
    chk("ext resume", 32'(ucnt), 32'h0000_0002);
    apb(1, OFS_CTRL, 32'h0000_0004);
    apb(1, OFS_CTRL, 32'h0000_0010);
    repeat (3) @(posedge pclk);
    chk("chosen timebase", 32'(tb), 32'(TB_10M));
    give_verdict();
  end
endmodule
